// ===== rtl/ppadc_cycle.sv
// conversion sequencer and 3-wire serial output port
//
// What this block does
// - first conversion uses channel 0, then channels alternate each conversion.
// - cycle repeats conversion, sleep, data output; starts with a conversion.
// - after conversion, sleep while chip select stays high.
// - sleeping keeps the finished result in the shift register indefinitely.
// - chip select low wakes the block into data output.
// - chip select high before first rising clock returns to sleep, result kept.
// - after first rising clock, shift out; chip select high aborts, reconverts.
// - output bit changes on falling clock; host samples on rising clock.
// - data output ends after 32 bits or chip select high after first rising clock; then reconvert.
// - serial data output high impedance from the clock after chip select goes high.
// - in conversion and sleep, chip select low shows the pending status.
// - internal mode drives clock pin only during data output with chip select low, pull-up on in internal mode only; external mode it is input.
// - clock mode taken from clock pin at reset release or chip select fall.
// - frequency input high selects 50Hz null, low selects 60Hz null.
// - external clock on frequency input is system clock, null at f/2560.
// - output word belongs to the conversion that has just finished.
// - no configuration registers; modes come only from pin timing.
// - word is pending, channel, sign, 24-bit result msb first, 5 sub bits.
// - first bit high while converting; second bit high for channel 1.
// - sign and msb both high is overrange, both low underrange.
`timescale 1ns/100ps
`include "ppadc_consts.svh"

module ppadc_cycle #(
  parameter int CONV_CYC = `PPADC_CONV_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_cs_n,
  input  wire logic                  i_sck,
  input  wire logic                  i_notch_freq_select_input,
  input  wire logic                  i_fext_tick,
  input  wire logic                  i_fext_mode,
  input  wire ppadc_pkg::ppadc_result_t i_result,
  output logic                       o_sdo,
  output logic                       o_sdo_oe_n,
  output logic                       o_sck,
  output logic                       o_sck_oe_n,
  output logic                       o_sck_pullup,
  output logic                       o_conv_start,
  output logic                       o_conv_chan,
  output logic                       o_notch_50hz,
  output logic                       o_ext_sysclk,
  output logic [11:0]                o_null_div
);

  ppadc_pkg::ppadc_state_t state_r;
  logic [31:0]  conv_cnt_r;
  logic [31:0]  shift_r;
  logic [5:0]   bit_cnt_r;
  logic         chan_r;
  logic         started_r;
  logic         int_mode_r;
  logic         cs_d_r;
  logic         sck_d_r;
  logic         isck_r;
  logic [3:0]   isck_cnt_r;
  logic         arst_seen_r;
  logic         sck_eff;
  logic         sck_rise;
  logic         sck_fall;
  logic         cs_fall;
  logic         conv_done;
  logic         word_done;

  //////////////////////////////////////////////////////////////////////////
  // clock edges and pin sampling

  // serial clock source follows latched mode
  assign sck_eff  = int_mode_r ? isck_r : i_sck;
  assign sck_rise = sck_eff & ~sck_d_r;
  assign sck_fall = ~sck_eff & sck_d_r;
  assign cs_fall  = ~i_cs_n & cs_d_r;
  assign conv_done = (state_r == ppadc_pkg::PPADC_CONV) &&
                     (conv_cnt_r == 32'(CONV_CYC - 1));
  assign word_done = (state_r == ppadc_pkg::PPADC_DOUT) && started_r &&
                     sck_fall && (bit_cnt_r == 6'(`PPADC_WORD_BITS - 1));

  // edge history registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b1; // idle high level of the host-driven clock pin in external mode
    end else begin
      cs_d_r  <= i_cs_n;
      sck_d_r <= sck_eff;
    end
  end

  // clock mode latch: first edge after reset, then each chip select fall
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      arst_seen_r <= 1'b0;
      int_mode_r  <= 1'b0;
    end else begin
      arst_seen_r <= 1'b1;
      if (!arst_seen_r || cs_fall) begin
        int_mode_r <= ~i_sck;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // internal serial clock divider

  // runs only while internal mode drives an output word
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      isck_r     <= 1'b0;
      isck_cnt_r <= 4'h0;
    end else if (int_mode_r && !i_cs_n &&
                 state_r == ppadc_pkg::PPADC_DOUT) begin
      if (isck_cnt_r == 4'(`PPADC_ISCK_HALF - 1)) begin
        isck_cnt_r <= 4'h0;
        isck_r     <= ~isck_r;
      end else begin
        isck_cnt_r <= isck_cnt_r + 4'h1;
      end
    end else begin
      isck_r     <= 1'b0;
      isck_cnt_r <= 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // cycle state machine

  // conversion, sleep, data output
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ppadc_pkg::PPADC_CONV;
    end else begin
      unique case (state_r)
        ppadc_pkg::PPADC_CONV: begin
          if (conv_done) begin
            state_r <= ppadc_pkg::PPADC_SLEEP;
          end
        end
        ppadc_pkg::PPADC_SLEEP: begin
          if (!i_cs_n) begin
            state_r <= ppadc_pkg::PPADC_DOUT;
          end
        end
        ppadc_pkg::PPADC_DOUT: begin
          if (i_cs_n) begin
            state_r <= started_r ? ppadc_pkg::PPADC_CONV
                                 : ppadc_pkg::PPADC_SLEEP;
          end else if (word_done) begin
            state_r <= ppadc_pkg::PPADC_CONV;
          end
        end
      endcase
    end
  end

  // conversion timer, base rate from the system or external clock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      conv_cnt_r <= 32'h0000_0000;
    end else if (state_r != ppadc_pkg::PPADC_CONV) begin
      conv_cnt_r <= 32'h0000_0000;
    end else if (!i_fext_mode || i_fext_tick) begin
      conv_cnt_r <= conv_cnt_r + 32'h0000_0001;
    end
  end

  // channel alternation at word end or late deselect, before the next conversion
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chan_r <= `PPADC_RST_CHAN;
    end else if (state_r == ppadc_pkg::PPADC_DOUT &&
                 (word_done || (i_cs_n && started_r))) begin
      chan_r <= ~chan_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output shift register

  // load on conversion end, hold in sleep, shift on falling clock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_r   <= 32'h0000_0000;
      bit_cnt_r <= 6'h00;
      started_r <= 1'b0;
    end else if (conv_done) begin
      shift_r   <= {1'b0, chan_r, i_result.sign, i_result.value,
                    i_result.sub};
      bit_cnt_r <= 6'h00;
      started_r <= 1'b0;
    end else if (state_r == ppadc_pkg::PPADC_DOUT && !i_cs_n) begin
      if (sck_rise) begin
        started_r <= 1'b1;
      end
      if (started_r && sck_fall) begin
        shift_r   <= {shift_r[30:0], 1'b0};
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end else if (state_r != ppadc_pkg::PPADC_DOUT) begin
      started_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers

  // data pin: status outside output state, tri-state when deselected
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sdo      <= 1'b1;
      o_sdo_oe_n <= 1'b1;
    end else begin
      o_sdo_oe_n <= i_cs_n;
      if (state_r == ppadc_pkg::PPADC_DOUT) begin
        o_sdo <= shift_r[`PPADC_BIT_PEND];
      end else begin
        o_sdo <= (state_r == ppadc_pkg::PPADC_CONV);
      end
    end
  end

  // clock pin direction and pull-up
  assign o_sck        = isck_r;
  assign o_sck_oe_n   = ~(int_mode_r && !i_cs_n &&
                          state_r == ppadc_pkg::PPADC_DOUT);
  assign o_sck_pullup = int_mode_r;

  // analog side controls, from cycle state, channel register and pins
  assign o_conv_start = (state_r == ppadc_pkg::PPADC_CONV) &&
                        (conv_cnt_r == 32'h0000_0000);
  assign o_conv_chan  = chan_r;
  assign o_notch_50hz = i_notch_freq_select_input;
  assign o_ext_sysclk = i_fext_mode;
  assign o_null_div   = 12'(`PPADC_NULL_DIV);

  //////////////////////////////////////////////////////////////////////////
  // checks

  // deselect once clocking of the word has begun
  sequence deselect_s;
    (state_r == ppadc_pkg::PPADC_DOUT) && started_r && i_cs_n;
  endsequence

  // deselect before any rising clock of the word
  sequence early_desel_s;
    (state_r == ppadc_pkg::PPADC_DOUT) && !started_r && i_cs_n;
  endsequence

  // one falling clock step of a started word
  sequence shift_step_s;
    (state_r == ppadc_pkg::PPADC_DOUT) && !i_cs_n && started_r && sck_fall;
  endsequence

  // cycle order, output word and pin behaviour
  first_chan_a: assert property (@(posedge i_clk)
    $rose(i_arst_n) |-> !chan_r)
    else $error("channel not 0 after reset");

  conv_sleep_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    conv_done |=> state_r == ppadc_pkg::PPADC_SLEEP)
    else $error("no sleep after conversion");

  sleep_hold_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r == ppadc_pkg::PPADC_SLEEP && i_cs_n) |=>
      ($stable(shift_r) && state_r == ppadc_pkg::PPADC_SLEEP))
    else $error("sleep lost result");

  wake_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r == ppadc_pkg::PPADC_SLEEP && !i_cs_n) |=>
      state_r == ppadc_pkg::PPADC_DOUT)
    else $error("no wake on select");

  early_abort_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    early_desel_s |=>
      (state_r == ppadc_pkg::PPADC_SLEEP && $stable(shift_r)))
    else $error("early deselect not back to sleep");

  chan_keep_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    early_desel_s |=> $stable(chan_r))
    else $error("early deselect moved channel");

  late_abort_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    deselect_s |=> state_r == ppadc_pkg::PPADC_CONV)
    else $error("abort did not reconvert");

  shift_fall_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    shift_step_s |=> (shift_r == ($past(shift_r) << 1)))
    else $error("word not shifted on falling clock");

  shift_keep_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (!conv_done && !(state_r == ppadc_pkg::PPADC_DOUT && !i_cs_n &&
                     started_r && sck_fall)) |=> $stable(shift_r))
    else $error("word moved without a falling clock");

  word_end_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    word_done && !i_cs_n |=> (state_r == ppadc_pkg::PPADC_CONV
                              && chan_r != $past(chan_r)))
    else $error("word end not handled");

  hiz_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    i_cs_n [*2] |-> o_sdo_oe_n)
    else $error("data pin driven while deselected");

  oe_follow_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    !i_cs_n |=> !o_sdo_oe_n)
    else $error("data pin not driven while selected");

  status_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r == ppadc_pkg::PPADC_CONV) [*2] |-> o_sdo)
    else $error("status not high while converting");

  sleep_status_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r == ppadc_pkg::PPADC_SLEEP) |=> !o_sdo)
    else $error("status not low after conversion");

  isck_idle_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r != ppadc_pkg::PPADC_DOUT) |=> !o_sck)
    else $error("internal clock running outside output");

  mode_latch_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    cs_fall |=> (int_mode_r == !$past(i_sck)))
    else $error("clock mode not taken at select");

  ext_hold_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r == ppadc_pkg::PPADC_CONV && !conv_done && i_fext_mode &&
     !i_fext_tick) |=> $stable(conv_cnt_r))
    else $error("timer moved without external tick");

  load_word_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    conv_done |=>
      (shift_r == {1'b0, $past(chan_r), $past(i_result)}))
    else $error("finished result not loaded");

  conv_start_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    ((state_r != ppadc_pkg::PPADC_CONV) ##1
     (state_r == ppadc_pkg::PPADC_CONV)) |-> o_conv_start)
    else $error("conversion start not flagged");

  cycle_order_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r == ppadc_pkg::PPADC_CONV) |=>
      (state_r != ppadc_pkg::PPADC_DOUT))
    else $error("output entered straight from conversion");

  sleep_order_a: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    (state_r == ppadc_pkg::PPADC_SLEEP) |=>
      (state_r != ppadc_pkg::PPADC_CONV))
    else $error("conversion entered straight from sleep");

endmodule // ppadc_cycle

// ===== rtl/ppadc_consts.svh
// timing counts, field positions and reset values for the ping-pong cycle
`ifndef PPADC_CONSTS_SVH
`define PPADC_CONSTS_SVH
`define PPADC_CLK_MHZ        100
`define PPADC_WORD_BITS      32
`define PPADC_RES_BITS       24
`define PPADC_SUB_BITS       5
`define PPADC_BIT_PEND       31
`define PPADC_BIT_CHAN       30
`define PPADC_BIT_SIGN       29
`define PPADC_BIT_MSB        28
`define PPADC_NULL_DIV       2560
`define PPADC_CONV_US        1000
`define PPADC_CONV_CYC       (`PPADC_CONV_US * `PPADC_CLK_MHZ)
`define PPADC_ISCK_HALF      8
`define PPADC_RST_CHAN       1'b0
`endif

// ===== rtl/ppadc_pkg.sv
// types for the ping-pong converter cycle
package ppadc_pkg;
  typedef enum logic [2:0] {
    PPADC_CONV  = 3'b001,
    PPADC_SLEEP = 3'b010,
    PPADC_DOUT  = 3'b100
  } ppadc_state_t;

  typedef struct packed {
    logic        sign;
    logic [23:0] value;
    logic [4:0]  sub;
  } ppadc_result_t;
endpackage

// ===== test/ppadc_host.sv
// host-side serial master model for the ping-pong converter port
`timescale 1ns/100ps
module ppadc_host (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  input  wire logic i_sck_wire,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_sck_en
);
  initial begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b1;
    o_sck_en = 1'b1;
  end
  // step n clocks and move just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // bounded wait for a level on the shared clock wire
  task automatic wait_sck(input logic lvl, inout bit ok);
    int t;
    for (t = 0; t < 40 && i_sck_wire !== lvl; t++) tick(1);
    if (t == 40) ok = 1'b0;
  endtask
  // select, poll status low, clock in nbits; nbits 0 is an early deselect
  task automatic read_word(input bit int_mode, input int nbits,
                           output logic [31:0] w, output logic st,
                           output bit ok);
    int t;
    w = '0;
    o_sck = !int_mode;
    tick(1);
    o_cs_n = 1'b0;
    tick(1);
    // released pin floats to the pull-up; device takes it over
    if (int_mode) o_sck_en = 1'b0;
    tick(1);
    st = i_sdo;
    for (t = 0; t < 400 && i_sdo !== 1'b0; t++) tick(1);
    ok = (t < 400);
    for (int i = 0; i < nbits; i++) begin
      if (!int_mode) begin
        // half periods of four clocks, above the two-clock floor
        o_sck = 1'b0;
        tick(4);
        o_sck = 1'b1;
      end else
        wait_sck(1'b0, ok);
      wait_sck(1'b1, ok);
      w = {w[30:0], i_sdo};
      if (!int_mode) tick(4);
    end
    // last falling edge closes a full word
    if (nbits == 32) begin
      o_sck = 1'b0;
      if (int_mode) wait_sck(1'b0, ok);
      else tick(4);
    end
    tick(1);
    o_cs_n   = 1'b1;
    o_sck_en = 1'b1;
    o_sck    = 1'b1;
    tick(2);
  endtask
endmodule // ppadc_host

// ===== test/tb_ppadc_cycle.sv
// self-checking bench for the ping-pong conversion cycle
`timescale 1ns/100ps
module tb_ppadc_cycle;
  logic                      i_clk = 1'b0;
  logic                      i_arst_n = 1'b0;
  logic                      i_notch = 1'b0;
  logic                      i_fext_tick = 1'b0;
  logic                      i_fext_mode = 1'b0;
  ppadc_pkg::ppadc_result_t  i_result = '0;
  ppadc_pkg::ppadc_result_t  res;
  logic                      cs_n, h_sck, h_sck_en, sck_wire;
  logic                      o_sdo, o_sdo_oe_n, o_sck, o_sck_oe_n;
  logic                      o_sck_pullup, o_conv_chan, o_notch_50hz;
  logic                      o_ext_sysclk;
  logic [11:0]               o_null_div;
  logic [31:0]               w;
  logic                      st, ch, exp_st;
  bit                        ok, md;
  int                        nb, miscompares, checked, cyc;

  // clock wire: device drives when enabled, else host, else pull-up
  assign sck_wire = !o_sck_oe_n ? o_sck : (h_sck_en ? h_sck : 1'b1);
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) i_fext_tick <= #1 1'($urandom % 2);

  ppadc_cycle #(.CONV_CYC(50)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_sck(sck_wire),
    .i_notch_freq_select_input(i_notch), .i_fext_tick(i_fext_tick),
    .i_fext_mode(i_fext_mode), .i_result(i_result), .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n),
    .o_sck_pullup(o_sck_pullup), .o_conv_start(), .o_conv_chan(o_conv_chan),
    .o_notch_50hz(o_notch_50hz), .o_ext_sysclk(o_ext_sysclk),
    .o_null_div(o_null_div));
  ppadc_host host (
    .i_clk(i_clk), .i_sdo(o_sdo), .i_sck_wire(sck_wire), .o_cs_n(cs_n),
    .o_sck(h_sck), .o_sck_en(h_sck_en));

  // expected word: pending, channel, sign, result, sub bits
  function automatic logic [31:0] exp_word(input logic c,
                                           input ppadc_pkg::ppadc_result_t r);
    return {1'b0, c, r.sign, r.value, r.sub};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // main sequence: words, early deselects, aborts, both clock modes
  initial begin
    void'($urandom(23));
    repeat (16) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    ch = 1'b0;
    exp_st = 1'b1;
    check(o_null_div, 12'hA00);
    for (int k = 0; k < 12; k++) begin
      i_notch     = 1'($urandom % 2);
      i_fext_mode = 1'($urandom % 2);
      // two corner words first: over- and underrange codes
      if (k < 2) i_result = k ? '0 : '1;
      else i_result = ppadc_pkg::ppadc_result_t'(30'($urandom));
      res = i_result;
      md  = (k >= 2) && ($urandom % 2);
      nb  = (k % 4 == 3) ? 1 + $urandom % 31 : 32;
      host.tick(1);
      check(o_notch_50hz, i_notch);
      check(o_ext_sysclk, i_fext_mode);
      if (k % 3 == 1) begin
        host.read_word(1'b0, 0, w, st, ok);
        check(st, exp_st);
        i_result = ~res;
        exp_st = 1'b0;
      end
      host.read_word(md, nb, w, st, ok);
      check(ok, 1);
      check(st, exp_st);
      check(w, exp_word(ch, res) >> (32 - nb));
      check(o_sdo_oe_n, 1);
      check(o_sck_pullup, md);
      ch = ~ch;
      check(o_conv_chan, ch);
      exp_st = 1'b1;
    end
    tally_and_finish();
  end
endmodule // tb_ppadc_cycle
